// *** hw/svm_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef SVM_MAP_SVH
`define SVM_MAP_SVH
// ****************************************
// register byte addresses
// ****************************************
`define SVM_CTRL_ADDR 12'h000
`define SVM_STAT_ADDR 12'h004
`define SVM_MASK_ADDR 12'h008
// ****************************************
// control register fields
// ****************************************
`define SVM_LVL_LSB 0
`define SVM_LVL_MSB 2
`define SVM_EN_BIT 4
`define SVM_IND_BIT 5
`define SVM_CTRL_WMASK 8'h17
`define SVM_CTRL_RST 8'h00
// ****************************************
// status and mask fields
// ****************************************
`define SVM_FLAG_BIT 0
`define SVM_WAKE_BIT 1
`define SVM_EVT_W 2
`define SVM_FLAG_CP_BIT 8
`define SVM_FLAG_LD_BIT 9
// ****************************************
// timing
// ****************************************
`define SVM_CLK_MHZ 40
`define SVM_DELAY_US 16
`define SVM_DELAY_CYC (`SVM_DELAY_US * `SVM_CLK_MHZ)
`endif

// *** hw/svm_pkg.sv ***
// types shared by the supply voltage monitor
package svm_pkg;
  // flag delay sequencer states
  typedef enum logic [1:0] {
    SVM_IDLE = 2'b00,
    SVM_WAIT = 2'b01,
    SVM_DONE = 2'b10
  } svm_dly_e;
  // trip level code
  typedef logic [2:0] svm_lvl_t;
endpackage

// *** hw/svm_top.sv ***
// supply voltage monitor control, flag delay, wake-up and apb slave
`timescale 1ns/1ps
`include "svm_map.svh"
module svm_top #(
  parameter int DELAY_CYC = `SVM_DELAY_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // analog side
  input wire logic cmp_low_in,
  input wire logic power_down_in,
  output logic detector_on_out,
  output logic ref_on_out,
  output logic [2:0] trip_level_select_out,
  // core side
  output logic wake_out,
  output logic low_supply_request_flag_out,
  output logic irq_out
);
  localparam int CW = $clog2(DELAY_CYC + 1);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_s1_q, rst_n_q;
  // release through two flops so every flop leaves reset on one edge
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ****************************************
  // register state
  // ****************************************
  logic detector_on_q; // enable bit
  svm_pkg::svm_lvl_t trip_level_select_q; // trip level code
  logic [`SVM_EVT_W-1:0] mask_q; // interrupt mask
  logic [`SVM_EVT_W-1:0] stat_q; // sticky status
  logic cmp_s1_q, cmp_s2_q; // comparator synchroniser
  logic low_supply_indication_q; // readable indication
  logic flag_q; // low supply request flag
  logic flag_prev_q; // for edge detect
  logic wake_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  svm_pkg::svm_dly_e dly_q;
  logic [CW-1:0] cnt_q;

  // apb decode: pready is registered, so every access phase takes two cycles
  logic acc, wr, rd, hit_ctrl, hit_stat, hit_mask, mapped;
  assign acc = psel_in && penable_in && !pready_q;
  assign wr = acc && pwrite_in;
  assign rd = acc && !pwrite_in;
  assign hit_ctrl = paddr_in == `SVM_CTRL_ADDR;
  assign hit_stat = paddr_in == `SVM_STAT_ADDR;
  assign hit_mask = paddr_in == `SVM_MASK_ADDR;
  assign mapped = hit_ctrl || hit_stat || hit_mask;

  // ****************************************
  // control register
  // ****************************************
  // only enable and level bits are writable
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      detector_on_q <= 1'b0;
      trip_level_select_q <= 3'h0;
    end else if (wr && hit_ctrl) begin
      detector_on_q <= pwdata_in[`SVM_EN_BIT];
      trip_level_select_q <=
        pwdata_in[`SVM_LVL_MSB:`SVM_LVL_LSB];
    end
  end

  // mask register
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= '0;
    end else if (wr && hit_mask) begin
      mask_q <= pwdata_in[`SVM_EVT_W-1:0];
    end
  end

  // ****************************************
  // comparator path
  // ****************************************
  // comparator is asynchronous; first flop read only by second
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= cmp_low_in;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // indication follows the comparator only while detector is on;
  // power-down does not gate it
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      low_supply_indication_q <= 1'b0;
    end else begin
      low_supply_indication_q <= detector_on_q && cmp_s2_q;
    end
  end

  // ****************************************
  // flag raise delay
  // ****************************************
  // restarts whenever indication drops, so toggling near the level
  // only sets the flag once it has stayed low-supply for the delay
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dly_q <= svm_pkg::SVM_IDLE;
      cnt_q <= '0;
    end else if (!low_supply_indication_q) begin
      dly_q <= svm_pkg::SVM_IDLE;
      cnt_q <= '0;
    end else begin
      case (dly_q)
        svm_pkg::SVM_IDLE: begin
          dly_q <= svm_pkg::SVM_WAIT;
          cnt_q <= CW'(1);
        end
        svm_pkg::SVM_WAIT: begin
          if (cnt_q >= CW'(DELAY_CYC)) begin
            dly_q <= svm_pkg::SVM_DONE;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        svm_pkg::SVM_DONE: begin
          dly_q <= svm_pkg::SVM_DONE;
        end
        default: begin
          dly_q <= svm_pkg::SVM_IDLE;
        end
      endcase
    end
  end

  logic flag_set;
  assign flag_set = dly_q == svm_pkg::SVM_WAIT && low_supply_indication_q
    && cnt_q >= CW'(DELAY_CYC);

  // ****************************************
  // request flag
  // ****************************************
  // a status write with bit 9 set loads the flag from bit 8; control
  // bits 7 and 6 stay unused, so a control write never touches it
  logic flag_load;
  assign flag_load = wr && hit_stat && pwdata_in[`SVM_FLAG_LD_BIT];
  // set event wins over a software clear in the same cycle, so a drop
  // that lands on the clear is never lost
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (flag_load) begin
      flag_q <= pwdata_in[`SVM_FLAG_CP_BIT];
    end
  end

  // rising flag edge gives a wake pulse whatever the mask
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flag_prev_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      flag_prev_q <= flag_q;
      wake_q <= flag_q && !flag_prev_q;
    end
  end

  // ****************************************
  // sticky status and interrupt
  // ****************************************
  logic [`SVM_EVT_W-1:0] evt;
  assign evt = {wake_q && power_down_in, flag_set};
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < `SVM_EVT_W; i++) begin
        if (evt[i]) begin
          stat_q[i] <= 1'b1;
        end else if (wr && hit_stat && pwdata_in[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // ****************************************
  // apb read and answer
  // ****************************************
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (hit_ctrl) begin
      // bits 7, 6 and 3 stay zero
      rmux[`SVM_IND_BIT] = low_supply_indication_q;
      rmux[`SVM_EN_BIT] = detector_on_q;
      rmux[`SVM_LVL_MSB:`SVM_LVL_LSB] = trip_level_select_q;
    end else if (hit_stat) begin
      rmux[`SVM_EVT_W-1:0] = stat_q;
      rmux[`SVM_FLAG_CP_BIT] = flag_q;
    end else if (hit_mask) begin
      rmux[`SVM_EVT_W-1:0] = mask_q;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q <= rd ? rmux : 32'h0000_0000;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign detector_on_out = detector_on_q;
  assign ref_on_out = detector_on_q;
  assign trip_level_select_out = trip_level_select_q;
  assign wake_out = wake_q;
  assign low_supply_request_flag_out = flag_q;
  assign irq_out = irq_q;

  // ****************************************
  // checks
  // ****************************************
  // helper for the checks: consecutive cycles of indication high,
  // held at the delay so a long low-supply spell cannot wrap it
  logic [CW-1:0] ind_run_q;
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ind_run_q <= '0;
    end else if (!low_supply_indication_q) begin
      ind_run_q <= '0;
    end else if (ind_run_q != CW'(DELAY_CYC)) begin
      ind_run_q <= ind_run_q + CW'(1);
    end
  end

  // a software load may raise the flag at any time, so the first three
  // checks below leave those cycles out
  a_flag_delay: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    $rose(flag_q) && !$past(flag_load) |-> $past(low_supply_indication_q))
    else $error("flag set without low indication");
  a_flag_wait: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    $rose(flag_q) && !$past(flag_load) |->
    $past(ind_run_q) == CW'(DELAY_CYC))
    else $error("flag set before the raise delay ran out");
  a_flag_early: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    !flag_load && ind_run_q != CW'(DELAY_CYC) |=> $stable(flag_q))
    else $error("flag moved before the raise delay ran out");
  a_ind_gate: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    !detector_on_q |=> !low_supply_indication_q)
    else $error("indication high while detector off");
  a_wake_edge: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    $rose(flag_q) |=> wake_q)
    else $error("no wake on flag rise");
  a_wake_once: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    wake_q |-> $past(flag_q) && !$past(flag_q, 2))
    else $error("wake without a flag rise");
  a_sleep_wake: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    wake_q && power_down_in |=> stat_q[`SVM_WAKE_BIT])
    else $error("wake in power-down not recorded");
  a_flag_hold: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    $fell(flag_q) |-> $past(flag_load && !pwdata_in[`SVM_FLAG_CP_BIT]))
    else $error("flag cleared without write");
  a_ref_follow: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    $past(wr && hit_ctrl) |-> ref_on_out == $past(pwdata_in[`SVM_EN_BIT]))
    else $error("reference not following enable");
  a_unused_zero: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    pready_q && $past(hit_ctrl) |->
    prdata_q[7:6] == 2'b00 && !prdata_q[3])
    else $error("unused bits read nonzero");
  // indication is the comparator three edges back: two sync stages
  // and the gated indication flop
  a_sync_two: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    low_supply_indication_q ==
    ($past(detector_on_q) && $past(cmp_low_in, 3)))
    else $error("indication missed synced comparator");
  a_no_early: assert property (
    @(posedge clock_in) disable iff (!rst_n_q)
    $rose(low_supply_indication_q) && !flag_q |=> !flag_q)
    else $error("flag set with no delay");
endmodule

// *** verif/svm_top_test.sv ***
// self-checking bench for the supply voltage monitor
`timescale 1ns/1ps
`include "svm_map.svh"
module svm_top_test;
  // ****************************************
  // stimulus and dut
  // ****************************************
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic cmp_low = 1'b0;
  logic pdown = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, det_on, ref_on;
  logic [2:0] lvl;
  logic wake, flag, irq;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  logic [31:0] rd;
  logic err;
  // ordinary control writes and the read-back they give
  logic [7:0] row_wd [8] = '{8'h00, 8'h19, 8'h0a, 8'h1b, 8'hec, 8'h15,
                             8'h3e, 8'h17};
  logic [7:0] row_exp [8] = '{8'h00, 8'h11, 8'h02, 8'h13, 8'h04, 8'h15,
                              8'h16, 8'h17};
  // short delay keeps the run small
  svm_top #(.DELAY_CYC(8)) u_dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cmp_low_in(cmp_low), .power_down_in(pdown),
    .detector_on_out(det_on), .ref_on_out(ref_on),
    .trip_level_select_out(lvl), .wake_out(wake),
    .low_supply_request_flag_out(flag), .irq_out(irq));
  always #12.5 clock_in = ~clock_in;
  // ****************************************
  // tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_in);
    penable <= 1'b1;
    // wait for the answer; a dead slave is caught by the cycle ceiling
    do begin
      @(posedge clock_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // count wake pulses over a fixed watch window
  task automatic wakes(input int len);
    n = 0;
    repeat (len) begin
      @(negedge clock_in);
      if (wake === 1'b1) n++;
    end
    @(posedge clock_in);
  endtask
  // a stuck run counts as a mismatch
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rchk(`SVM_CTRL_ADDR, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `SVM_CTRL_ADDR, {24'h00_0000, row_wd[i]});
      rchk(`SVM_CTRL_ADDR, {24'h00_0000, row_exp[i]});
      chk({29'h0, lvl}, {29'h0, row_exp[i][2:0]});
      chk({31'h0, det_on}, {31'h0, row_exp[i][4]});
      chk({31'h0, ref_on}, {31'h0, row_exp[i][4]});
      chk({31'h0, flag}, 32'h0000_0000);
    end
    // let the detector settle before its indication is trusted
    repeat (8) @(posedge clock_in);
    // supply drops: indication now, flag only after the delay
    cmp_low <= 1'b1;
    repeat (9) @(negedge clock_in);
    chk({31'h0, flag}, 32'h0000_0000);
    n = 0;
    while (flag !== 1'b1 && n < 30) begin
      @(negedge clock_in);
      n++;
    end
    chk({31'h0, flag}, 32'h0000_0001);
    @(posedge clock_in);
    rchk(`SVM_CTRL_ADDR, 32'h0000_0037);
    cmp_low <= 1'b0;
    rchk(`SVM_STAT_ADDR, 32'h0000_0101);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `SVM_MASK_ADDR, 32'h0000_0001);
    @(negedge clock_in);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `SVM_STAT_ADDR, 32'h0000_0001);
    @(negedge clock_in);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(`SVM_STAT_ADDR, 32'h0000_0100);
    apb(1'b1, `SVM_STAT_ADDR, 32'h0000_0200);
    chk({31'h0, flag}, 32'h0000_0000);
    // slow crossing: toggling indication never completes the delay
    for (int i = 0; i < 10; i++) begin
      cmp_low <= ~cmp_low;
      repeat (6) @(posedge clock_in);
    end
    chk({31'h0, flag}, 32'h0000_0000);
    // drop while asleep wakes the core once
    pdown <= 1'b1;
    cmp_low <= 1'b1;
    wakes(40);
    chk(n, 32'h0000_0001);
    chk({31'h0, flag}, 32'h0000_0001);
    rchk(`SVM_STAT_ADDR, 32'h0000_0103);
    // flag preset high while asleep suppresses the wake-up
    cmp_low <= 1'b0;
    apb(1'b1, `SVM_STAT_ADDR, 32'h0000_0303);
    cmp_low <= 1'b1;
    wakes(40);
    chk(n, 32'h0000_0000);
    rchk(`SVM_STAT_ADDR, 32'h0000_0101);
    // detector off: indication gated to zero
    apb(1'b1, `SVM_CTRL_ADDR, 32'h0000_0002);
    repeat (5) @(posedge clock_in);
    rchk(`SVM_CTRL_ADDR, 32'h0000_0002);
    chk({31'h0, ref_on}, 32'h0000_0000);
    // unmapped place refused
    rchk(12'h00c, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    // reset in mid-run clears the register
    nrst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rchk(`SVM_CTRL_ADDR, 32'h0000_0000);
    chk({30'h0, irq, flag}, 32'h0000_0000);
    summarize();
  end
endmodule
